//--- design/aict_defines.svh
`ifndef AICT_DEFINES_SVH
`define AICT_DEFINES_SVH

`define AICT_CLK_NS 25
`define AICT_TICK_NS 4000
`define AICT_TICK_CYC ((`AICT_TICK_NS + `AICT_CLK_NS - 1) / `AICT_CLK_NS)
`define AICT_XFER_NS 64000
`define AICT_XFER_CYC (`AICT_XFER_NS / `AICT_CLK_NS)

`define AICT_CNT_W 7
`define AICT_DATA_W 6
`define AICT_PRE_W 14
`define AICT_RATE_MAX 4'hD
`define AICT_CONV_W 11
`define AICT_PATCH_LSB 5
`define AICT_OVF_BIT 6

`define AICT_SYNC_W 23
`define AICT_SY_CONTACT 0
`define AICT_SY_CONV 6
`define AICT_SY_SRC 17
`define AICT_SY_SENSE 18
`define AICT_SY_RATE 19

`define AICT_FC_W 15
`define AICT_FC_SAMPLED 15'h1A00
`define AICT_FC_COUNTER 15'h1A01
`define AICT_FC_ALTERNATE 15'h1A02
`define AICT_FC_SENSE 15'h4A00
`endif

//--- design/aict_pkg.sv
package aict_pkg;
  typedef enum logic [1:0] {
    AICT_SEL_SAMPLED = 2'h0,
    AICT_SEL_COUNTER = 2'h1,
    AICT_SEL_ALT = 2'h3
  } aict_sel_t;
endpackage

//--- design/aict_in_if.sv
`include "aict_defines.svh"
interface aict_in_if;
  logic [`AICT_SYNC_W-1:0] raw;
  logic [`AICT_SYNC_W-1:0] synced;
  modport drv(output raw, input synced);
  modport syn(input raw, output synced);
endinterface

//--- design/aict_sync.sv
`include "aict_defines.svh"
module aict_sync (
  input wire logic clk,
  input wire logic srst,
  aict_in_if.syn port
);
  logic [`AICT_SYNC_W-1:0] meta_q;
  logic [`AICT_SYNC_W-1:0] stab_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      stab_q <= '0;
    end else begin
      meta_q <= port.raw;
      stab_q <= meta_q;
    end
  end

  assign port.synced = stab_q;
endmodule

//--- design/aict_top.sv
`include "aict_defines.svh"
module aict_top (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic [5:0] CONTACT_INPUT,
  input wire logic [10:0] CONVERTER_PATCH_INPUT,
  input wire logic INPUT_SOURCE_SELECT,
  input wire logic CHANGE_SENSE_SELECT,
  input wire logic [3:0] ADVANCE_RATE_SELECT,
  input wire logic FUNC_STROBE,
  input wire logic [14:0] FUNC_CODE,
  input wire logic INPUT_REQ,
  output logic [6:0] INPUT_DATA,
  output logic INPUT_VALID,
  output logic CHANGE_FLAG,
  output logic SENSE_AND_JUMP
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [`AICT_PRE_W-1:0] rate_mask(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > `AICT_RATE_MAX) ? `AICT_RATE_MAX : sel;
    rate_mask = `AICT_PRE_W'((`AICT_PRE_W'(1) << s) - `AICT_PRE_W'(1));
  endfunction

  function automatic logic reads_sampled(input aict_pkg::aict_sel_t m, input logic phase);
    reads_sampled = (m == aict_pkg::AICT_SEL_SAMPLED) || (m == aict_pkg::AICT_SEL_ALT && !phase);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  aict_in_if sif ();

  assign sif.raw = {ADVANCE_RATE_SELECT, CHANGE_SENSE_SELECT, INPUT_SOURCE_SELECT,
                    CONVERTER_PATCH_INPUT, CONTACT_INPUT};

  aict_sync u_sync (
    .clk(MCLK),
    .srst(SRST),
    .port(sif)
  );

  wire [5:0] contact_s = sif.synced[`AICT_SY_CONTACT +: `AICT_DATA_W];
  wire [10:0] conv_s = sif.synced[`AICT_SY_CONV +: `AICT_CONV_W];
  wire src_conv_s = sif.synced[`AICT_SY_SRC];
  wire sense_input_s = sif.synced[`AICT_SY_SENSE];
  wire [3:0] rate_s = sif.synced[`AICT_SY_RATE +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: 4 us base tick then fourteen free binary stages
  logic [7:0] tick_cnt_q;
  logic [`AICT_PRE_W-1:0] pre_q;
  logic [`AICT_CNT_W-1:0] count_q;

  wire tick = (tick_cnt_q == 8'(`AICT_TICK_CYC - 1));
  // stages are only read, never cleared by host traffic
  wire advance = tick && ((pre_q | ~rate_mask(rate_s)) == {`AICT_PRE_W{1'b1}});
  wire ovf_evt = advance && (count_q == 7'h7F);

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      tick_cnt_q <= 8'h00;
      pre_q <= '0;
    end else begin
      tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;
      if (tick) begin
        pre_q <= pre_q + `AICT_PRE_W'(1);
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      count_q <= '0;
    end else if (advance) begin
      count_q <= count_q + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter patch: default routing takes the six top outputs
  wire [5:0] conv_routed;
  genvar gi;
  generate
    for (gi = 0; gi < `AICT_DATA_W; gi++) begin : g_patch
      assign conv_routed[gi] = conv_s[`AICT_PATCH_LSB + gi];
    end
  endgenerate

  wire [5:0] data_src = src_conv_s ? conv_routed : contact_s;

  ////////////////////////////////////////////////////////////////////////////
  aict_pkg::aict_sel_t mode_q;
  logic alt_phase_q;
  logic sense_sel_q;
  logic [5:0] data_q;
  logic ovf_q;
  logic chg_q;

  wire fc_sampled = FUNC_STROBE && (FUNC_CODE == `AICT_FC_SAMPLED);
  wire fc_counter = FUNC_STROBE && (FUNC_CODE == `AICT_FC_COUNTER);
  wire fc_alt = FUNC_STROBE && (FUNC_CODE == `AICT_FC_ALTERNATE);
  wire fc_sense = FUNC_STROBE && (FUNC_CODE == `AICT_FC_SENSE);
  wire rd_text = INPUT_REQ && reads_sampled(mode_q, alt_phase_q);
  wire ovf_rise = ovf_evt && !ovf_q;
  // in input mode a cleared overflow is not itself a change, or the flag could never clear
  wire chg_evt = sense_input_s ? ((data_src != data_q) || ovf_rise) : ovf_rise;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      mode_q <= aict_pkg::AICT_SEL_SAMPLED;
      alt_phase_q <= 1'b0;
      sense_sel_q <= 1'b0;
    end else begin
      if (fc_sampled) begin
        mode_q <= aict_pkg::AICT_SEL_SAMPLED;
      end else if (fc_counter) begin
        mode_q <= aict_pkg::AICT_SEL_COUNTER;
      end else if (fc_alt) begin
        mode_q <= aict_pkg::AICT_SEL_ALT;
      end
      if (fc_sampled || fc_counter || fc_alt) begin
        alt_phase_q <= 1'b0;
      end else if (INPUT_REQ && mode_q == aict_pkg::AICT_SEL_ALT) begin
        alt_phase_q <= !alt_phase_q;
      end
      if (FUNC_STROBE) begin
        sense_sel_q <= fc_sense;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      data_q <= '0;
      ovf_q <= 1'b0;
      chg_q <= 1'b0;
    end else begin
      data_q <= data_src;
      if (ovf_evt) begin
        ovf_q <= 1'b1;
      end else if (rd_text) begin
        ovf_q <= 1'b0;
      end
      if (chg_evt) begin
        chg_q <= 1'b1;
      end else if (rd_text && !ovf_evt) begin
        chg_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle answer keeps far ahead of the 64 us host spacing
  logic [6:0] out_data_q;
  logic out_valid_q;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      out_data_q <= 7'h00;
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= INPUT_REQ;
      if (INPUT_REQ) begin
        out_data_q <= rd_text ? {ovf_q, data_q} : count_q;
      end
    end
  end

  assign INPUT_DATA = out_data_q;
  assign INPUT_VALID = out_valid_q;
  assign CHANGE_FLAG = chg_q;
  assign SENSE_AND_JUMP = sense_sel_q && chg_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  // steps of alternate mode: a read in phase 0 then a read in phase 1
  sequence s_alt_first;
    INPUT_REQ && !FUNC_STROBE && (mode_q == aict_pkg::AICT_SEL_ALT) && !alt_phase_q;
  endsequence

  sequence s_alt_second;
    INPUT_REQ && !FUNC_STROBE && (mode_q == aict_pkg::AICT_SEL_ALT) && alt_phase_q;
  endsequence

  counter_step_a: assert property (advance |=> count_q == $past(count_q) + 7'h01)
    else $error("counter did not step on advance");

  counter_hold_a: assert property (!advance |=> $stable(count_q))
    else $error("counter moved without advance");

  tick_space_a: assert property (tick |=> !tick [*8])
    else $error("base tick too close");

  fast_rate_a: assert property (tick && rate_s == 4'h0 |-> advance)
    else $error("fastest rate missed a tick");

  ovf_set_a: assert property (advance && count_q == 7'h7F |=> ovf_q && count_q == 7'h00)
    else $error("wrap did not set overflow");

  ovf_keep_a: assert property (ovf_q && !rd_text |=> ovf_q)
    else $error("overflow lost without read");

  ovf_race_a: assert property (ovf_evt && rd_text |=> ovf_q)
    else $error("overflow lost in clear cycle");

  // a fresh input change in the read cycle may set the change flag again
  ovf_clear_a: assert property (rd_text && !ovf_evt |=> !ovf_q && (!chg_q || $past(chg_evt)))
    else $error("read did not clear flags");

  chg_keep_a: assert property (chg_q && !rd_text |=> chg_q)
    else $error("change flag cleared early");

  chg_ovf_a: assert property (!sense_input_s && ovf_rise |=> chg_q)
    else $error("overflow change not flagged");

  answer_time_a: assert property (INPUT_REQ |=> INPUT_VALID ##1 (INPUT_VALID == $past(INPUT_REQ)))
    else $error("answer not one cycle after request");

  text_data_a: assert property (rd_text |=> INPUT_DATA == {$past(ovf_q), $past(data_q)})
    else $error("sampled read returned wrong data");

  route_a: assert property (src_conv_s |=> data_q == $past(conv_s[10:5]))
    else $error("converter routing wrong");

  alt_order_a: assert property (s_alt_first |=> alt_phase_q && INPUT_DATA == {$past(ovf_q), $past(data_q)})
    else $error("alternate first read not sampled register");

  alt_back_a: assert property (s_alt_second |=> !alt_phase_q && INPUT_DATA == $past(count_q))
    else $error("alternate mode did not switch to counter");

  sense_route_a: assert property (fc_sense |=> SENSE_AND_JUMP == chg_q)
    else $error("sense not routed to change flag");
endmodule

//--- bench/aict_host_model.sv
`include "aict_defines.svh"
module aict_host_model (
  input wire logic clk,
  input wire logic [6:0] data,
  input wire logic valid,
  output logic stb,
  output logic [14:0] code,
  output logic req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    stb = 1'b0;
    code = 15'h7FFF;
    req = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic func(input logic [14:0] c);
    @(posedge clk);
    stb <= 1'b1;
    code <= c;
    @(posedge clk);
    stb <= 1'b0;
    // idle code inverted so a stale word never looks fresh
    code <= ~c;
    repeat (2) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic rd(output logic [6:0] d, output logic ok);
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    #1;
    ok = valid;
    d = data;
    // pads each transfer out to the minimum host spacing
    repeat (`AICT_XFER_CYC - 2) @(posedge clk);
  endtask
endmodule

//--- bench/aict_top_bench.sv
`include "aict_defines.svh"
module aict_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] contact = 6'h00;
  logic [10:0] conv = 11'h000;
  logic src_sel = 1'b0;
  logic sense_sel = 1'b0;
  logic [3:0] rate = 4'hD;
  logic fstb;
  logic ireq;
  logic ivalid;
  logic cflag;
  logic saj;
  logic [14:0] fcode;
  logic [6:0] idata;
  logic [6:0] a;
  logic [6:0] b;
  int n_fail = 0;
  int cmp_count = 0;
  always #12.5 mclk = ~mclk;
  aict_top dut_u (
    .MCLK(mclk),
    .SRST(srst),
    .CONTACT_INPUT(contact),
    .CONVERTER_PATCH_INPUT(conv),
    .INPUT_SOURCE_SELECT(src_sel),
    .CHANGE_SENSE_SELECT(sense_sel),
    .ADVANCE_RATE_SELECT(rate),
    .FUNC_STROBE(fstb),
    .FUNC_CODE(fcode),
    .INPUT_REQ(ireq),
    .INPUT_DATA(idata),
    .INPUT_VALID(ivalid),
    .CHANGE_FLAG(cflag),
    .SENSE_AND_JUMP(saj)
  );
  aict_host_model hm_u (
    .clk(mclk),
    .data(idata),
    .valid(ivalid),
    .stb(fstb),
    .code(fcode),
    .req(ireq)
  );
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(output logic [6:0] d);
    logic ok;
    hm_u.rd(d, ok);
    chk({6'h00, ok}, 7'h01);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    ticks(2);
    chk(idata, 7'h00);
    chk({6'h00, cflag}, 7'h00);
    hm_u.func(`AICT_FC_COUNTER);
    // reads are exactly sixteen base ticks apart
    for (int n = 0; n < 4; n++) begin
      rate <= n[3:0];
      ticks(4);
      rd(a);
      rd(b);
      chk(b - a, 7'h10 >> n);
    end
    // slowest rate keeps the counter still for the data checks until the overflow test
    rate <= 4'hD;
    contact <= 6'h2A;
    ticks(4);
    hm_u.func(`AICT_FC_SAMPLED);
    rd(a);
    chk(a, 7'h2A);
    contact <= 6'h15;
    ticks(4);
    rd(a);
    chk(a, 7'h15);
    chk({6'h00, cflag}, 7'h00);
    hm_u.func(`AICT_FC_COUNTER);
    rd(b);
    hm_u.func(`AICT_FC_ALTERNATE);
    rd(a);
    chk(a, 7'h15);
    rd(a);
    chk(a, b);
    rd(a);
    chk(a, 7'h15);
    hm_u.func(`AICT_FC_SAMPLED);
    src_sel <= 1'b1;
    conv <= 11'h560;
    ticks(4);
    rd(a);
    chk(a, 7'h2B);
    sense_sel <= 1'b1;
    ticks(4);
    conv <= 11'h160;
    ticks(4);
    chk({6'h00, cflag}, 7'h01);
    rd(a);
    chk(a, 7'h0B);
    chk({6'h00, cflag}, 7'h00);
    sense_sel <= 1'b0;
    rate <= 4'h0;
    hm_u.func(`AICT_FC_COUNTER);
    for (int i = 0; i < 22000 && cflag !== 1'b1; i++) begin
      @(posedge mclk);
    end
    chk({6'h00, cflag}, 7'h01);
    if (cflag !== 1'b1) begin
      conclude;
    end
    hm_u.func(`AICT_FC_SENSE);
    chk({6'h00, saj}, 7'h01);
    hm_u.func(`AICT_FC_SAMPLED);
    chk({6'h00, saj}, 7'h00);
    rd(a);
    chk(a, 7'h4B);
    chk({6'h00, cflag}, 7'h00);
    rd(a);
    chk(a, 7'h0B);
    conclude;
  end
endmodule
